// ===== hdl/pcrr_pkg.sv
// pcrr_pkg: register selects, field layout and sizes for the result registers
// shared by the result register block and its bench
package pcrr_pkg;
   localparam int          PCRR_PORTS          = 4;
   localparam int          PCRR_PORT_W         = 2;
   localparam int          PCRR_SEL_W          = 4;
   localparam int          PCRR_DATA_W         = 8;
   localparam int          PCRR_RES_W          = 15;
   localparam logic [3:0]  PCRR_SEL_CUR_LOW    = 4'ha;
   localparam logic [3:0]  PCRR_SEL_CUR_HIGH   = 4'hb;
   localparam logic [3:0]  PCRR_SEL_TEMP_LOW   = 4'hc;
   localparam logic [3:0]  PCRR_SEL_TEMP_HIGH  = 4'hd;
   localparam int          PCRR_DONE_BIT       = 7;
   localparam logic [14:0] PCRR_RES_RESET      = 15'h0000;
   localparam logic        PCRR_DONE_RESET     = 1'b0;
   localparam logic [7:0]  PCRR_UNMAPPED_DATA  = 8'h00;
endpackage

// ===== hdl/pcrr_result_regs.sv
// pcrr_result_regs: per-port current and temperature result registers
// assumes conversion events come from logic on ref_clk, one-cycle pulses
//
// Behaviour
// - select 1010 returns current result bits 7..0, reset zero
// - select 1011 bits 6..0 return current result bits 14..8, reset zero
// - current done flag clears when a current conversion starts
// - current done flag sets when a current conversion finishes, reset zero
// - select 1100 returns temperature result bits 7..0, reset zero
// - select 1101 bits 6..0 return temperature bits 14..8, reset zero
// - temperature done flag clears when a temperature conversion starts
// - temperature done flag sets when temperature conversion finishes, reset zero
// - each port keeps its own copy; port select picks the copy read
`timescale 1ns/1ps
`default_nettype none
module pcrr_result_regs
   import pcrr_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   rst_b,
   input  wire logic [PCRR_PORT_W-1:0] cvtPort,
   input  wire logic                   curStart,
   input  wire logic                   curDone,
   input  wire logic                   tempStart,
   input  wire logic                   tempDone,
   input  wire logic [PCRR_RES_W-1:0]  cvtResult,
   input  wire logic                   rdStrobe,
   input  wire logic [PCRR_PORT_W-1:0] rdPort,
   input  wire logic [PCRR_SEL_W-1:0]  rdSel,
   output logic [PCRR_DATA_W-1:0]      rdData,
   output logic                        rdValid
);
   // stored results and completion flags, one copy per port
   logic [PCRR_RES_W-1:0]  curRes_reg   [PCRR_PORTS];
   logic [PCRR_RES_W-1:0]  tempRes_reg  [PCRR_PORTS];
   logic [PCRR_PORTS-1:0]  curDone_reg;
   logic [PCRR_PORTS-1:0]  tempDone_reg;

   // per-port event strobes
   logic [PCRR_PORTS-1:0]  curStartHit;
   logic [PCRR_PORTS-1:0]  curDoneHit;
   logic [PCRR_PORTS-1:0]  tempStartHit;
   logic [PCRR_PORTS-1:0]  tempDoneHit;

   // read path
   logic                   selCurLow;
   logic                   selCurHigh;
   logic                   selTempLow;
   logic                   selTempHigh;
   logic [PCRR_RES_W-1:0]  curWord;
   logic [PCRR_RES_W-1:0]  tempWord;
   logic                   curFlag;
   logic                   tempFlag;
   logic [PCRR_DATA_W-1:0] rdData_next;
   logic                   rdValid_next;

   // one-hot port mask for an event on the given port
   function automatic logic [PCRR_PORTS-1:0] portMask(input logic                   hit,
                                                      input logic [PCRR_PORT_W-1:0] port);
      logic [PCRR_PORTS-1:0] mask;
      mask = '0;
      for (int i = 0; i < PCRR_PORTS; i++) begin
         if (hit && (port == i[PCRR_PORT_W-1:0])) begin
            mask[i] = 1'b1;
         end
      end
      portMask = mask;
   endfunction

   // lower byte of a result word
   function automatic logic [PCRR_DATA_W-1:0] lowByte(input logic [PCRR_RES_W-1:0] res);
      lowByte = res[PCRR_DATA_W-1:0];
   endfunction

   // upper byte: completion flag over result bits 14..8
   function automatic logic [PCRR_DATA_W-1:0] upperByte(input logic                  flag,
                                                        input logic [PCRR_RES_W-1:0] res);
      logic [PCRR_DATA_W-1:0] byteOut;
      byteOut = {flag, res[PCRR_RES_W-1:PCRR_DATA_W]};
      upperByte = byteOut;
   endfunction

   // select code match
   function automatic logic selIs(input logic [PCRR_SEL_W-1:0] sel,
                                  input logic [PCRR_SEL_W-1:0] code);
      selIs = (sel == code);
   endfunction

   // event decode per port
   always_comb begin
      curStartHit  = portMask(curStart, cvtPort);
      curDoneHit   = portMask(curDone, cvtPort);
      tempStartHit = portMask(tempStart, cvtPort);
      tempDoneHit  = portMask(tempDone, cvtPort);
   end

   // current result words, whole word in one edge
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < PCRR_PORTS; i++) begin
            curRes_reg[i] <= PCRR_RES_RESET;
         end
      end else begin
         for (int i = 0; i < PCRR_PORTS; i++) begin
            if (curDoneHit[i]) begin
               curRes_reg[i] <= cvtResult;
            end
         end
      end
   end

   // temperature result words, whole word in one edge
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < PCRR_PORTS; i++) begin
            tempRes_reg[i] <= PCRR_RES_RESET;
         end
      end else begin
         for (int i = 0; i < PCRR_PORTS; i++) begin
            if (tempDoneHit[i]) begin
               tempRes_reg[i] <= cvtResult;
            end
         end
      end
   end

   // current done flags, finish wins over a start
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         curDone_reg <= {PCRR_PORTS{PCRR_DONE_RESET}};
      end else begin
         for (int i = 0; i < PCRR_PORTS; i++) begin
            if (curDoneHit[i]) begin
               curDone_reg[i] <= 1'b1;
            end else if (curStartHit[i]) begin
               curDone_reg[i] <= 1'b0;
            end
         end
      end
   end

   // temperature done flags, finish wins over a start
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tempDone_reg <= {PCRR_PORTS{PCRR_DONE_RESET}};
      end else begin
         for (int i = 0; i < PCRR_PORTS; i++) begin
            if (tempDoneHit[i]) begin
               tempDone_reg[i] <= 1'b1;
            end else if (tempStartHit[i]) begin
               tempDone_reg[i] <= 1'b0;
            end
         end
      end
   end

   // select decode and port copy pick
   always_comb begin
      selCurLow   = selIs(rdSel, PCRR_SEL_CUR_LOW);
      selCurHigh  = selIs(rdSel, PCRR_SEL_CUR_HIGH);
      selTempLow  = selIs(rdSel, PCRR_SEL_TEMP_LOW);
      selTempHigh = selIs(rdSel, PCRR_SEL_TEMP_HIGH);
      curWord     = curRes_reg[rdPort];
      tempWord    = tempRes_reg[rdPort];
      curFlag     = curDone_reg[rdPort];
      tempFlag    = tempDone_reg[rdPort];
   end

   // read data mux
   always_comb begin
      if (selCurLow) begin
         rdData_next = lowByte(curWord);
      end else if (selCurHigh) begin
         rdData_next = upperByte(curFlag, curWord);
      end else if (selTempLow) begin
         rdData_next = lowByte(tempWord);
      end else if (selTempHigh) begin
         rdData_next = upperByte(tempFlag, tempWord);
      end else begin
         rdData_next = PCRR_UNMAPPED_DATA;
      end
   end

   // answer strobe one cycle after the request
   always_comb begin
      rdValid_next = rdStrobe;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdValid <= 1'b0;
      end else begin
         rdValid <= rdValid_next;
      end
   end

   // read data holds until the next request
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdData <= PCRR_UNMAPPED_DATA;
      end else begin
         if (rdStrobe) begin
            rdData <= rdData_next;
         end
      end
   end
endmodule
`default_nettype wire

// ===== bench/pcrr_checker.sv
// pcrr_checker: read and result assertions; bound onto the result block
`timescale 1ns/1ps
`default_nettype none
module pcrr_checker(
   input wire logic        ref_clk,
   input wire logic        rst_b,
   input wire logic        curStart,
   input wire logic        curDone,
   input wire logic        tempStart,
   input wire logic        tempDone,
   input wire logic        rdStrobe,
   input wire logic        rdValid,
   input wire logic [1:0]  cvtPort,
   input wire logic [1:0]  rdPort,
   input wire logic [14:0] cvtResult,
   input wire logic [3:0]  rdSel,
   input wire logic [7:0]  rdData
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   wire h = rdStrobe && rdPort == cvtPort;
   read_valid_a: assert property (rdStrobe |=> rdValid) else $error("no valid");
   read_idle_a: assert property (!rdStrobe |=> !rdValid) else $error("stray valid");
   reset_clear_a: assert property ($rose(rst_b) |-> rdData == 8'h00) else $error("rst");
   cur_low_a: assert property (
      curDone ##[2:4] h && rdSel == 4'ha |=> rdData == $past(cvtResult[7:0])) else $error("cur low");
   cur_high_a: assert property (
      curDone ##[2:4] h && rdSel == 4'hb |=> rdData[6:0] == $past(cvtResult[14:8]))
      else $error("cur high");
   cur_done_a: assert property (curDone ##[2:4] h && rdSel == 4'hb |=> rdData[7]) else $error("cd");
   cur_start_a: assert property (
      curStart && !curDone ##[2:4] h && rdSel == 4'hb |=> !rdData[7]) else $error("cs");
   temp_done_a: assert property (tempDone ##[2:4] h && rdSel == 4'hd |=> rdData[7]) else $error("td");
   temp_low_a: assert property (
      tempDone ##[2:4] h && rdSel == 4'hc |=> rdData == $past(cvtResult[7:0])) else $error("temp low");
   temp_high_a: assert property (
      tempDone ##[2:4] h && rdSel == 4'hd |=> rdData[6:0] == $past(cvtResult[14:8]))
      else $error("temp high");
   temp_start_a: assert property (
      tempStart && !tempDone ##[2:4] h && rdSel == 4'hd |=> !rdData[7]) else $error("ts");
endmodule
bind pcrr_result_regs pcrr_checker i_pcrr_checker(.ref_clk,.rst_b,.curStart,.curDone,.tempStart,
   .tempDone,.rdStrobe,.rdValid,.cvtPort,.rdPort,.cvtResult,.rdSel,.rdData);
`default_nettype wire

// ===== bench/pcrr_host.sv
// pcrr_host: host issuing one-cycle register reads at the falling edge
`timescale 1ns/1ps
`default_nettype none
module pcrr_host(input wire logic ref_clk,output logic s,output logic [1:0] p,output logic [3:0] c);
   initial {s,p,c} = 0;
   task rd(input logic [1:0] pp,input logic [3:0] cc);
      @(negedge ref_clk) {s,p,c} = {1'b1,pp,cc};
      @(negedge ref_clk) {s,p,c} = {1'b0,~pp,~cc};
   endtask
endmodule
`default_nettype wire

// ===== bench/pcrr_result_regs_bench.sv
// pcrr_result_regs_bench: conversion events then host reads, self-checking
`timescale 1ns/1ps
`default_nettype none
module pcrr_result_regs_bench;
   import pcrr_pkg::*;
   logic ref_clk = 0, rst_b = 0, cs, cd, ts, td, s, v;
   logic [1:0] cp, p;
   logic [3:0] c;
   logic [14:0] r;
   logic [7:0] d;
   int miscompares = 0, checked = 0;
   always #5 ref_clk = ~ref_clk;
   pcrr_host i_pcrr_host(.ref_clk,.s,.p,.c);
   pcrr_result_regs i_pcrr_result_regs(.ref_clk,.rst_b,.cvtPort(cp),.curStart(cs),.curDone(cd),
      .tempStart(ts),.tempDone(td),.cvtResult(r),.rdStrobe(s),.rdPort(p),.rdSel(c),.rdData(d),.rdValid(v));
   task ev(input logic [1:0] pt,input logic [3:0] k,input logic [14:0] x);
      @(negedge ref_clk) {cp,cs,cd,ts,td,r} = {pt,k,x};
      @(negedge ref_clk) {cs,cd,ts,td} = 0;
   endtask
   task chk(input logic [1:0] pt,input logic [3:0] sl,input logic [7:0] e);
      i_pcrr_host.rd(pt,sl);
      checked++;
      if (d !== e || v !== 1'b1) begin
         miscompares++;
         $display("wrong value rdData sel %h exp %h got %h valid %b", sl, e, d, v);
      end
   endtask
   task conclude;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      {cs,cd,ts,td,cp,r} = 0;
      repeat (8) @(negedge ref_clk);
      rst_b = 1;
      for (int k = 10; k < 14; k++) chk(3, k[3:0], 8'h00);
      ev(1, 4'b0100, 15'h5a3c);
      chk(1, 4'ha, 8'h3c);
      chk(1, 4'hb, 8'hda);
      chk(0, 4'hb, 8'h00);
      ev(2, 4'b0001, 15'h1234);
      chk(2, 4'hd, 8'h92);
      chk(2, 4'hc, 8'h34);
      ev(2, 4'b1010, 15'h0000);
      chk(2, 4'hd, 8'h12);
      chk(2, 4'hb, 8'h00);
      chk(1, 4'hf, 8'h00);
      ev(0, 4'b1100, 15'h7fff);
      chk(0, 4'hb, 8'hff);
      $display("result tests done");
      conclude();
   end
endmodule
`default_nettype wire
